// ### hw/chan_ctrl_reg.sv
/*
  one channel's divider and spread control register, with the decoded controls that drive the
  fractional divider and the spread modulator.
  the raw word is kept for read-back; o_ctl is decoded from the same word in the same cycle,
  so the controls never lag the register by a clock.
  assumes the configuration port turns its serial traffic into single-cycle write and read
  strobes on i_clk_sys, so no strobe needs synchronising here.
  assumes the divider and modulator downstream sample o_ctl on i_clk_sys and that only one
  address is presented per strobe.
*/
`timescale 1ns/100ps
module chan_ctrl_reg
  import chan_ctrl_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic [7:0]   i_addr,
  input  wire logic [15:0]  i_wdata,
  output logic      [15:0]  o_rdata,
  output logic              o_rvalid,
  output divider_ctl_s      o_ctl
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [15:0]  reg_val;
    logic [15:0]  rdata;
    logic         rvalid;
    divider_ctl_s ctl;
  } state_s;

  state_s st_q;
  state_s st_d;

  // ==========================================================================
  // address decode
  // the port presents one address per strobe and only the control word is mapped
  // a write to any other address is dropped without an answer
  function automatic logic hits_ctrl(input logic [7:0] addr);
    hits_ctrl = (addr == CTRL_ADDR);
  endfunction

  // ==========================================================================
  // write and read paths
  // reserved bits 2..1 never take a one, so their read-back is always zero
  function automatic logic [15:0] write_merge(input logic [15:0] wdata);
    write_merge = wdata & CTRL_WMASK;
  endfunction

  // unmapped addresses answer zero rather than a stale word
  function automatic logic [15:0] read_word(input logic [7:0] addr, input logic [15:0] val);
    if (hits_ctrl(addr)) begin
      read_word = val;
    end else begin
      read_word = 16'h0000;
    end
  endfunction

  // ==========================================================================
  // lookups
  // modulation period in spread counter cycles
  function automatic logic [9:0] period_of(input logic [1:0] code);
    case (code)
      2'h0: begin
        period_of = PERIOD_CODE0;
      end
      2'h1: begin
        period_of = PERIOD_CODE1;
      end
      2'h2: begin
        period_of = PERIOD_CODE2;
      end
      default: begin
        period_of = PERIOD_CODE3;
      end
    endcase
  endfunction

  // down-spread depth in hundredths of a percent of the carrier
  function automatic logic [9:0] down_depth_of(input logic [1:0] code);
    case (code)
      2'h0: begin
        down_depth_of = DEPTH_CODE0;
      end
      2'h1: begin
        down_depth_of = DEPTH_CODE1;
      end
      2'h2: begin
        down_depth_of = DEPTH_CODE2;
      end
      default: begin
        down_depth_of = DEPTH_CODE3;
      end
    endcase
  endfunction

  // center spread swings half the down figure either side of the carrier;
  // the halving is exact because every down figure is even
  function automatic logic [9:0] depth_of(input logic [1:0] code, input logic down);
    if (down) begin
      depth_of = down_depth_of(code);
    end else begin
      depth_of = down_depth_of(code) >> 1;
    end
  endfunction

  // ==========================================================================
  // field decode
  // one function per control; spread_on_of and depth_pct_of each read two fields of the word, the rest one
  // 1 runs the divider as a delay element, 0 as a synthesiser
  function automatic logic delay_mode_of(input logic [15:0] r);
    delay_mode_of = r[POS_DELAY_MODE];
  endfunction

  // 1 skips every register stage of the divider
  function automatic logic bypass_of(input logic [15:0] r);
    bypass_of = r[POS_BYPASS];
  endfunction

  // 1 holds the divider in reset, 0 lets it run
  function automatic logic div_reset_of(input logic [15:0] r);
    div_reset_of = r[POS_DIV_RESET];
  endfunction

  // spread counter clock: 0 from the divider output, 1 from the reference
  function automatic logic counter_src_of(input logic [15:0] r);
    counter_src_of = r[POS_CNT_SRC];
  endfunction

  // division applied to the spread counter clock
  function automatic logic [2:0] counter_div_of(input logic [15:0] r);
    counter_div_of = r[POS_CNT_DIV_LSB +: 3];
  endfunction

  // spread stays off while the divider is held in reset, because the divider
  // output, one of the two counter clock sources, is stopped then
  function automatic logic spread_on_of(input logic [15:0] r);
    spread_on_of = r[POS_SPREAD_EN] & ~r[POS_DIV_RESET];
  endfunction

  // 0 is center spread, 1 is down spread
  function automatic logic spread_down_of(input logic [15:0] r);
    spread_down_of = r[POS_TYPE];
  endfunction

  // depth follows the spread type, in hundredths of a percent of the carrier
  function automatic logic [9:0] depth_pct_of(input logic [15:0] r);
    depth_pct_of = depth_of(r[POS_DEPTH_LSB +: 2], r[POS_TYPE]);
  endfunction

  // modulation period in counter cycles
  function automatic logic [9:0] period_cycles_of(input logic [15:0] r);
    period_cycles_of = period_of(r[POS_PERIOD_LSB +: 2]);
  endfunction

  // not a divider control; carried through for the output switch
  function automatic logic smooth_of(input logic [15:0] r);
    smooth_of = r[POS_SMOOTH];
  endfunction

  // ==========================================================================
  // decode
  function automatic divider_ctl_s decode(input logic [15:0] r);
    divider_ctl_s c;
    c.delay_mode       = delay_mode_of(r);
    c.bypass           = bypass_of(r);
    c.div_reset        = div_reset_of(r);
    c.counter_from_ref = counter_src_of(r);
    c.counter_div      = counter_div_of(r);
    c.spread_active    = spread_on_of(r);
    c.spread_down      = spread_down_of(r);
    c.depth_centi_pct  = depth_pct_of(r);
    c.period_cycles    = period_cycles_of(r);
    c.smooth_switch    = smooth_of(r);
    decode = c;
  endfunction

  // decoded controls at reset come from the same decode, so the two cannot drift apart
  localparam divider_ctl_s CTL_AT_RESET = decode(CTRL_RESET);

  // ==========================================================================
  // next state
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (i_wr && hits_ctrl(i_addr)) begin
      st_d.reg_val = write_merge(i_wdata);
    end
    // a read in the same cycle as a write returns the word held before the write
    if (i_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = read_word(i_addr, st_q.reg_val);
    end
    st_d.ctl = decode(st_d.reg_val);
  end

  // ==========================================================================
  // registers
  // the reset word and its decode are both constants, so the reset branch needs no clock
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q.reg_val <= CTRL_RESET;
      st_q.rdata   <= 16'h0000;
      st_q.rvalid  <= 1'b0;
      st_q.ctl     <= CTL_AT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs, each straight from the state register
  assign o_rdata  = st_q.rdata;
  assign o_rvalid = st_q.rvalid;
  assign o_ctl    = st_q.ctl;

endmodule

// ### hw/chan_ctrl_pkg.sv
/*
  constants and carrier types for the output-channel divider and spread control register.
  assumes a serial configuration port elsewhere presents decoded word reads and writes.
*/
package chan_ctrl_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0]  CTRL_ADDR     = 8'h2d;
  localparam logic [15:0] CTRL_RESET    = 16'h0071;
  localparam logic [15:0] CTRL_WMASK    = 16'hfff9;

  // ==========================================================================
  // field positions
  localparam int POS_DELAY_MODE  = 15;
  localparam int POS_BYPASS      = 14;
  localparam int POS_DIV_RESET   = 13;
  localparam int POS_CNT_SRC     = 12;
  localparam int POS_CNT_DIV_LSB = 9;
  localparam int POS_TYPE        = 8;
  localparam int POS_DEPTH_LSB   = 6;
  localparam int POS_PERIOD_LSB  = 4;
  localparam int POS_SPREAD_EN   = 3;
  localparam int POS_SMOOTH      = 0;

  // ==========================================================================
  // modulation period in counter cycles per code
  localparam logic [9:0] PERIOD_CODE0 = 10'h0f0;
  localparam logic [9:0] PERIOD_CODE1 = 10'h190;
  localparam logic [9:0] PERIOD_CODE2 = 10'h208;
  localparam logic [9:0] PERIOD_CODE3 = 10'h22c;

  // depth in hundredths of a percent of carrier, down-spread figure
  localparam logic [9:0] DEPTH_CODE0 = 10'h032;
  localparam logic [9:0] DEPTH_CODE1 = 10'h064;
  localparam logic [9:0] DEPTH_CODE2 = 10'h0c8;
  localparam logic [9:0] DEPTH_CODE3 = 10'h1f4;

  typedef struct packed {
    logic       delay_mode;
    logic       bypass;
    logic       div_reset;
    logic       counter_from_ref;
    logic [2:0] counter_div;
    logic       spread_active;
    logic       spread_down;
    logic [9:0] depth_centi_pct;
    logic [9:0] period_cycles;
    logic       smooth_switch;
  } divider_ctl_s;

endpackage

// ### test/chan_ctrl_props.sv
/* assertions on the channel divider and spread control register ports.
   assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/100ps
module chan_ctrl_props import chan_ctrl_pkg::*; (
  input wire logic         i_clk_sys,
  input wire logic         i_nrst,
  input wire logic         i_wr,
  input wire logic         i_rd,
  input wire logic [7:0]   i_addr,
  input wire logic [15:0]  i_wdata,
  input wire logic [15:0]  o_rdata,
  input wire logic         o_rvalid,
  input wire divider_ctl_s o_ctl
);
  // ==========================================================================
  // decode expectations
  localparam logic [9:0] PER [4] = '{PERIOD_CODE0, PERIOD_CODE1, PERIOD_CODE2, PERIOD_CODE3};
  localparam logic [9:0] DEP [4] = '{DEPTH_CODE0, DEPTH_CODE1, DEPTH_CODE2, DEPTH_CODE3};
  wire [15:0] w = i_wdata;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence hit_s; i_wr && i_addr == CTRL_ADDR; endsequence
  delay_mode_a: assert property (hit_s |=> o_ctl.delay_mode == $past(w[15])) else $error("delay mode");
  bypass_bit_a: assert property (hit_s |=> o_ctl.bypass == $past(w[14])) else $error("bypass");
  counter_src_a: assert property (hit_s |=> o_ctl.counter_from_ref == $past(w[12])) else $error("source");
  counter_div_a: assert property (hit_s |=> o_ctl.counter_div == $past(w[11:9])) else $error("division");
  spread_depth_a: assert property (hit_s |=> o_ctl.depth_centi_pct ==
    ($past(w[8]) ? DEP[$past(w[7:6])] : DEP[$past(w[7:6])] >> 1)) else $error("depth");
  mod_period_a: assert property (hit_s |=> o_ctl.period_cycles == PER[$past(w[5:4])]) else $error("period");
  spread_gate_a: assert property (hit_s |=> o_ctl.spread_active == ($past(w[3]) && !$past(w[13]))
    && o_ctl.spread_down == $past(w[8])) else $error("spread gate");
  div_reset_a: assert property (hit_s |=> o_ctl.div_reset == $past(w[13])) else $error("divider reset");
  ctl_hold_a: assert property (!i_wr |=> $stable(o_ctl)) else $error("control changed");
endmodule
bind chan_ctrl_reg chan_ctrl_props props_i (.i_clk_sys, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata,
  .o_rdata, .o_rvalid, .o_ctl);

// ### test/tb.sv
/* register access bench for the channel divider and spread control register.
   assumes single-cycle strobes and registered answers. */
`timescale 1ns/100ps
module tb import chan_ctrl_pkg::*;;
  // ==========================================================================
  // stimulus and checks
  logic         i_clk_sys = 0, i_nrst = 0, i_wr = 0, i_rd = 0, o_rvalid;
  logic [7:0]   i_addr = 8'h00;
  logic [15:0]  i_wdata = 16'h0000, o_rdata;
  divider_ctl_s o_ctl;
  int           err_total = 0, compares = 0;
  localparam logic [9:0] PER [4] = '{PERIOD_CODE0, PERIOD_CODE1, PERIOD_CODE2, PERIOD_CODE3};
  localparam logic [9:0] DEP [4] = '{DEPTH_CODE0, DEPTH_CODE1, DEPTH_CODE2, DEPTH_CODE3};
  chan_ctrl_reg uut (.i_clk_sys, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid, .o_ctl);
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(logic wr, logic [7:0] a, logic [15:0] d);
    @(posedge i_clk_sys) #1;
    i_wr = wr;
    i_rd = !wr;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk_sys) #1;
    i_wr = 0;
    i_rd = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    acc(0, a, 16'h0000);
    chk(o_rvalid, 1);
    chk(o_rdata, e);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // long enough for every test several times over
  initial begin
    #20000;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    #1 i_nrst = 1;
    rd(CTRL_ADDR, CTRL_RESET);
    chk(o_ctl, {7'h00, 2'b00, DEP[1] >> 1, PER[3], 1'b1});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      logic [15:0] v;
      v = {7'h00, k[0], k[1:0], 2'(3 - k), 4'h8};
      acc(1, CTRL_ADDR, v);
      chk(o_ctl.depth_centi_pct, k[0] ? DEP[k] : DEP[k] >> 1);
      chk(o_ctl.period_cycles, PER[3 - k]);
      chk({o_ctl.spread_active, o_ctl.spread_down}, {1'b1, k[0]});
      rd(CTRL_ADDR, v);
    end
    $display("test spread codes done");
    acc(1, CTRL_ADDR, 16'hffff);
    chk(o_ctl, {4'hf, 3'h7, 1'b0, 1'b1, DEP[3], PER[3], 1'b1});
    acc(1, 8'h2e, 16'h0008);
    rd(8'h2e, 16'h0000);
    rd(CTRL_ADDR, 16'hfff9);
    acc(1, CTRL_ADDR, 16'h0008);
    chk({o_ctl.delay_mode, o_ctl.div_reset, o_ctl.spread_active}, 3'h1);
    acc(1, CTRL_ADDR, 16'h5408);
    chk(o_ctl, {4'h5, 3'h2, 1'b1, 1'b0, DEP[0] >> 1, PER[0], 1'b0});
    $display("test control bits done");
    i_nrst = 0;
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_ctl, {7'h00, 2'b00, DEP[1] >> 1, PER[3], 1'b1});
    i_nrst = 1;
    rd(CTRL_ADDR, CTRL_RESET);
    $display("test reset again done");
    complete_run;
  end
endmodule
